// ---- logic/vss_regs.vh ----
//------------------------------------------------------------------
// voltage code and soft-start sequencer: constants
//------------------------------------------------------------------
// Behaviour
// - sample voltage code at channel-one cycle start
// - new code must hold one full cycle
// - step reference 25mV every second cycle
// - pulse-width outputs high impedance in shutdown
// - enable ignored until bias reset released
// - shutdown while enable below threshold
// - grounded rate_select_shutoff stops converter and oscillator
// - release of rate_select_shutoff restarts soft-start
// - all-ones code means no load: shutdown
// - any other code restarts after no-load shutdown
// - soft-start starts once all four conditions hold
// - 11-bit counter, one count per phase pulse
// - ramp level rises to 140% of reference
// - ramp current falls from 160uA to zero
// - regulate toward lower of reference and ramp
// - output_ok_flag follows window after start-up; the code follows it from the start of soft-start
// - code zero 1550mV, minus 25mV per step
`ifndef VSS_REGS_VH
`define VSS_REGS_VH

//------------------------------------------------------------------
// register map (byte addresses)
//------------------------------------------------------------------
`define VSS_ADDR_CTRL      8'h00
`define VSS_ADDR_STATUS    8'h04
`define VSS_ADDR_LEVEL     8'h08
`define VSS_ADDR_SOFT      8'h0C
`define VSS_CTRL_RST       32'h0001_0014
`define VSS_CTRL_PER_HI    15
`define VSS_CTRL_PER_LO    0
`define VSS_CTRL_PH_HI     17
`define VSS_CTRL_PH_LO     16

//------------------------------------------------------------------
// code decode and soft-start figures
//------------------------------------------------------------------
`define VSS_CODE_NOLOAD    5'h1F
`define VSS_REF_TOP_MV     11'h60E
`define VSS_REF_STEP_MV    11'h019
`define VSS_SS_LAST        11'h7FF
`define VSS_SS_FULL        12'h800
`define VSS_RAMP_NUM       25'h00_0007
`define VSS_RAMP_DEN       25'h00_2800
`define VSS_RAMP_UA_MAX    20'h0_00A0
`define VSS_SS_SHIFT       11

`endif

// ---- logic/vss_sync.v ----
`timescale 1ns/1ps
module vss_sync #(
  parameter W = 9
) (
  input  wire         ref_clk,
  input  wire         reset,
  input  wire [W-1:0] asyncIn,
  output wire [W-1:0] syncOut
);
  reg [W-1:0] meta_r;
  reg [W-1:0] stable_r;

  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
          meta_r[i]   <= 1'b0;
          stable_r[i] <= 1'b0;
        end else begin
          meta_r[i]   <= asyncIn[i];
          stable_r[i] <= meta_r[i];
        end
      end
    end
  endgenerate

  assign syncOut = stable_r;
endmodule

// ---- logic/vss_softstart.v ----
`timescale 1ns/1ps
`include "vss_regs.vh"
module vss_softstart (
  input  wire        ref_clk,
  input  wire        reset,
  input  wire        clear,
  input  wire        phasePulse,
  input  wire [10:0] refMv,
  output reg  [10:0] ssCount,
  output reg         ssDone,
  output reg  [11:0] rampMv,
  output reg  [7:0]  rampUa
);
  wire [11:0] effCount = ssDone ? `VSS_SS_FULL : {1'b0, ssCount};
  wire [24:0] rampProd = {13'd0, effCount} * {14'd0, refMv} * `VSS_RAMP_NUM;
  wire [24:0] rampQuot = rampProd / `VSS_RAMP_DEN;
  wire [19:0] curProd  = {8'd0, `VSS_SS_FULL - effCount} * `VSS_RAMP_UA_MAX;
  wire [19:0] curQuot  = curProd >> `VSS_SS_SHIFT;

  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ssCount <= 11'h000;
      ssDone  <= 1'b0;
      rampMv  <= 12'h000;
      rampUa  <= 8'h00;
    end else begin
      if (clear) begin
        ssCount <= 11'h000;
        ssDone  <= 1'b0;
      end else if (phasePulse && !ssDone) begin
        if (ssCount == `VSS_SS_LAST) begin
          ssDone <= 1'b1;
        end else begin
          ssCount <= ssCount + 11'h001;
        end
      end
      rampMv <= rampQuot[11:0];
      rampUa <= curQuot[7:0];
    end
  end
endmodule

// ---- logic/vss_sequencer.v ----
`timescale 1ns/1ps
`include "vss_regs.vh"
module vss_sequencer (
  input  wire        ref_clk,
  input  wire        reset,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // pins
  input  wire        porReleased,
  input  wire        enAboveThreshold,
  input  wire        rateSelectShutoff,
  input  wire        outputInWindow,
  input  wire [4:0]  voltageCode,
  // outputs
  output reg         pwmDriveEn,
  output reg         outputOkFlag,
  output reg  [10:0] refMv,
  output reg  [11:0] regulateMv,
  output wire [11:0] rampMv,
  output wire [7:0]  rampUa,
  output reg         ch1Start
);
  localparam ST_OFF  = 2'b00;
  localparam ST_SOFT = 2'b01;
  localparam ST_RUN  = 2'b10;

  //------------------------------------------------------------------
  // pin synchronisers
  //------------------------------------------------------------------
  wire [8:0] pinSync;

  vss_sync #(
    .W (9)
  ) u_sync (
    .ref_clk (ref_clk),
    .reset   (reset),
    .asyncIn ({voltageCode, outputInWindow, rateSelectShutoff,
               enAboveThreshold, porReleased}),
    .syncOut (pinSync)
  );

  wire       porOk    = pinSync[0];
  wire       enOk     = pinSync[1];
  wire       rssFree  = pinSync[2];
  wire       inWindow = pinSync[3];
  wire [4:0] codeS    = pinSync[8:4];

  // enable only counts once bias reset is released
  wire enGated = porOk & enOk;
  wire startOk = enGated & rssFree & (codeS != `VSS_CODE_NOLOAD);

  //------------------------------------------------------------------
  // control register
  //------------------------------------------------------------------
  reg  [31:0] ctrl_r;
  wire [15:0] period   = ctrl_r[`VSS_CTRL_PER_HI:`VSS_CTRL_PER_LO];
  wire [1:0]  phasesM1 = ctrl_r[`VSS_CTRL_PH_HI:`VSS_CTRL_PH_LO];

  //------------------------------------------------------------------
  // oscillator and phase clock
  //------------------------------------------------------------------
  reg  [15:0] oscCnt_r;
  reg         phasePulse_r;
  reg  [1:0]  phaseIdx_r;
  wire [16:0] oscNext = {1'b0, oscCnt_r} + 17'h0_0001;
  wire        oscWrap = (oscNext >= {1'b0, period});

  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      oscCnt_r     <= 16'h0000;
      phasePulse_r <= 1'b0;
      phaseIdx_r   <= 2'b00;
      ch1Start     <= 1'b0;
    end else if (!rssFree) begin
      // oscillator held while the shutoff input is grounded
      oscCnt_r     <= 16'h0000;
      phasePulse_r <= 1'b0;
      phaseIdx_r   <= 2'b00;
      ch1Start     <= 1'b0;
    end else begin
      ch1Start <= 1'b0;
      if (oscWrap) begin
        oscCnt_r     <= 16'h0000;
        phasePulse_r <= 1'b1;
      end else begin
        oscCnt_r     <= oscNext[15:0];
        phasePulse_r <= 1'b0;
      end
      if (phasePulse_r) begin
        if (phaseIdx_r >= phasesM1) begin
          phaseIdx_r <= 2'b00;
          ch1Start   <= 1'b1;
        end else begin
          phaseIdx_r <= phaseIdx_r + 2'b01;
        end
      end
    end
  end

  //------------------------------------------------------------------
  // soft-start counter and ramp
  //------------------------------------------------------------------
  reg  [1:0]  state_r;
  reg  [1:0]  state_nxt;
  wire [10:0] ssCount;
  wire        ssDone;

  vss_softstart u_soft (
    .ref_clk    (ref_clk),
    .reset      (reset),
    .clear      (state_r == ST_OFF),
    .phasePulse (phasePulse_r),
    .refMv      (refMv),
    .ssCount    (ssCount),
    .ssDone     (ssDone),
    .rampMv     (rampMv),
    .rampUa     (rampUa)
  );

  //------------------------------------------------------------------
  // sequencing state machine
  //------------------------------------------------------------------
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_OFF: begin
        if (startOk) begin
          state_nxt = ST_SOFT;
        end
      end
      ST_SOFT: begin
        if (!startOk) begin
          state_nxt = ST_OFF;
        end else if (ssDone) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!startOk) begin
          state_nxt = ST_OFF;
        end
      end
      default: begin
        state_nxt = ST_OFF;
      end
    endcase
  end

  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_r <= ST_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  //------------------------------------------------------------------
  // code tracking, validation and slewing
  //------------------------------------------------------------------
  reg [4:0] refCode_r;
  reg [4:0] targetCode_r;
  reg [4:0] pendCode_r;
  reg       pending_r;
  reg       stepTick_r;

  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      refCode_r    <= 5'h00;
      targetCode_r <= 5'h00;
      pendCode_r   <= 5'h00;
      pending_r    <= 1'b0;
      stepTick_r   <= 1'b0;
    end else if (state_r == ST_OFF) begin
      // start from the code in force at start-up
      refCode_r    <= codeS;
      targetCode_r <= codeS;
      pendCode_r   <= codeS;
      pending_r    <= 1'b0;
      stepTick_r   <= 1'b0;
    end else if (ch1Start) begin
      if (pending_r) begin
        if (codeS == pendCode_r) begin
          targetCode_r <= pendCode_r;
          pending_r    <= 1'b0;
          stepTick_r   <= 1'b0;
        end else if (codeS == targetCode_r) begin
          pending_r <= 1'b0;
        end else begin
          pendCode_r <= codeS;
        end
      end else if (codeS != targetCode_r) begin
        pendCode_r <= codeS;
        pending_r  <= 1'b1;
      end
      if (refCode_r != targetCode_r) begin
        stepTick_r <= ~stepTick_r;
        if (stepTick_r) begin
          // higher code is a lower voltage
          if (refCode_r < targetCode_r) begin
            refCode_r <= refCode_r + 5'h01;
          end else begin
            refCode_r <= refCode_r - 5'h01;
          end
        end
      end
    end
  end

  //------------------------------------------------------------------
  // analog-facing levels and flags
  //------------------------------------------------------------------
  wire [10:0] codeMv = `VSS_REF_TOP_MV - (`VSS_REF_STEP_MV * {6'd0, refCode_r});
  wire [11:0] refMv12 = {1'b0, refMv};

  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      refMv        <= 11'h000;
      regulateMv   <= 12'h000;
      pwmDriveEn   <= 1'b0;
      outputOkFlag <= 1'b0;
    end else begin
      refMv      <= codeMv;
      pwmDriveEn <= (state_nxt != ST_OFF);
      case (state_r)
        ST_SOFT: begin
          regulateMv   <= (rampMv < refMv12) ? rampMv : refMv12;
          outputOkFlag <= inWindow;
        end
        ST_RUN: begin
          regulateMv   <= refMv12;
          outputOkFlag <= inWindow;
        end
        default: begin
          regulateMv   <= 12'h000;
          outputOkFlag <= 1'b0;
        end
      endcase
    end
  end

  //------------------------------------------------------------------
  // apb slave
  //------------------------------------------------------------------
  // read data is captured in the setup cycle, so every access takes
  // exactly one access cycle; status may be one cycle old
  wire setupPh  = psel & ~penable;
  wire accessOk = psel & penable & pready;
  wire mapped   = (paddr == `VSS_ADDR_CTRL) || (paddr == `VSS_ADDR_STATUS) ||
                  (paddr == `VSS_ADDR_LEVEL) || (paddr == `VSS_ADDR_SOFT);
  reg [31:0] rdMux;

  always @* begin
    rdMux = 32'h0000_0000;
    case (paddr)
      `VSS_ADDR_CTRL:   rdMux = ctrl_r;
      `VSS_ADDR_STATUS: rdMux = {24'd0, pending_r, (refCode_r != targetCode_r),
                                 ssDone, outputOkFlag, pwmDriveEn, startOk, state_r};
      `VSS_ADDR_LEVEL:  rdMux = {4'd0, regulateMv, 5'd0, refMv};
      `VSS_ADDR_SOFT:   rdMux = {8'd0, rampUa, 5'd0, ssCount};
      default:          rdMux = 32'h0000_0000;
    endcase
  end

  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      ctrl_r  <= `VSS_CTRL_RST;
    end else begin
      pready <= setupPh;
      if (setupPh) begin
        prdata  <= pwrite ? 32'h0000_0000 : rdMux;
        pslverr <= ~mapped;
      end else if (accessOk) begin
        prdata  <= 32'h0000_0000;
        pslverr <= 1'b0;
      end
      if (accessOk && pwrite && (paddr == `VSS_ADDR_CTRL)) begin
        ctrl_r <= pwdata;
      end
    end
  end
endmodule

// ---- tb/vss_seq_chk.sv ----
`timescale 1ns/1ps
module vss_seq_chk (
  input wire logic        ref_clk,
  input wire logic        reset,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        porReleased,
  input wire logic        enAboveThreshold,
  input wire logic        rateSelectShutoff,
  input wire logic        outputInWindow,
  input wire logic [4:0]  voltageCode,
  input wire logic        pwmDriveEn,
  input wire logic        outputOkFlag,
  input wire logic [10:0] refMv,
  input wire logic [11:0] regulateMv,
  input wire logic [7:0]  rampUa
);
  // ----
  // properties
  // ----
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_allOk;
    porReleased && enAboveThreshold && rateSelectShutoff && voltageCode != 5'h1F;
  endsequence
  // pins pass two sync stages, then the drive register (flag one stage later, via state register): five edges of margin
  a_ready_next: assert property (s_setup |=> pready)
    else $error("no ready after setup");
  a_ready_once: assert property (pready |=> !pready)
    else $error("ready held");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_off_bias: assert property (!porReleased [*5] |=> !pwmDriveEn && !outputOkFlag)
    else $error("driving without bias");
  a_off_enable: assert property ((!enAboveThreshold) [*5] |=> !pwmDriveEn)
    else $error("driving while disabled");
  a_off_shutoff: assert property ($fell(rateSelectShutoff) ##1 !rateSelectShutoff [*4]
    |=> !pwmDriveEn) else $error("driving while shut off");
  a_off_noload: assert property ((voltageCode == 5'h1F) [*5] |=> !pwmDriveEn)
    else $error("driving on no-load code");
  a_start_all: assert property (s_allOk [*6] |=> pwmDriveEn)
    else $error("no start");
  a_ref_step: assert property ($changed(refMv) && $past(pwmDriveEn, 2) && pwmDriveEn
    |-> refMv == $past(refMv) + 11'h019 || refMv + 11'h019 == $past(refMv))
    else $error("reference jump");
  a_reg_lower: assert property (regulateMv <= {1'b0, refMv}
    || regulateMv <= {1'b0, $past(refMv)}) else $error("regulate above reference");
  a_ramp_cur: assert property (rampUa <= 8'hA0)
    else $error("ramp current high");
  a_ok_window: assert property ((!outputInWindow) [*4] |=> !outputOkFlag)
    else $error("ok outside window");
endmodule

// ---- tb/vss_cpu_model.sv ----
`timescale 1ns/1ps
module vss_cpu_model (
  input  wire logic       ref_clk,
  input  wire logic       reset,
  input  wire logic [4:0] codeReq,
  input  wire logic       enReq,
  output logic      [4:0] voltageCode,
  output logic            enAboveThreshold
);
  logic [2:0] drvCnt_r;
  // ----
  // drivers and processor
  // ----
  always @(posedge ref_clk or posedge reset) begin
    if (reset)
      drvCnt_r <= 3'h0;
    else if (drvCnt_r != 3'h7)
      drvCnt_r <= drvCnt_r + 3'h1;
  end
  // enable withheld until the drivers leave their own reset
  assign enAboveThreshold = enReq && drvCnt_r == 3'h7;
  // no-load code only requested when the load is gone
  always @(posedge ref_clk) begin
    voltageCode <= codeReq;
  end
endmodule

// ---- tb/test_vss_sequencer.sv ----
`timescale 1ns/1ps
module test_vss_sequencer;
  logic        ref_clk, reset, psel, penable, pwrite, pready, pslverr, rerr;
  logic [7:0]  paddr, rampUa;
  logic [31:0] pwdata, prdata, rdat;
  logic        porReleased, enReq, enAboveThreshold, rateSelectShutoff;
  logic        outputInWindow, pwmDriveEn, outputOkFlag, ch1Start;
  logic [4:0]  codeReq, voltageCode;
  logic [10:0] refMv;
  logic [11:0] regulateMv, rampMv;
  int          err_count = 0;
  int          total_checks = 0;
  int          n;
  logic [4:0]  rowCode [5] = '{5'h00, 5'h1E, 5'h10, 5'h0A, 5'h08};
  logic [10:0] rowMv [5]   = '{11'h60E, 11'h320, 11'h47E, 11'h514, 11'h546};

  vss_sequencer u_dut (.ref_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .porReleased, .enAboveThreshold, .rateSelectShutoff,
    .outputInWindow, .voltageCode, .pwmDriveEn, .outputOkFlag, .refMv, .regulateMv,
    .rampMv, .rampUa, .ch1Start);
  vss_cpu_model u_cpu (.ref_clk, .reset, .codeReq, .enReq, .voltageCode,
    .enAboveThreshold);

  // ----
  // tasks
  // ----
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge ref_clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) err_count++;
    rdat = prdata;
    rerr = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic waitbit(ref logic s, input logic v);
    int k;
    for (k = 0; k < 30 && s !== v; k++) @(posedge ref_clk);
    chk(s, v);
  endtask
  // step spacing measured in clocks: two channel-one cycles of four
  task automatic slew(input logic [10:0] e);
    int k, g;
    logic [10:0] p;
    g = 99;
    p = refMv;
    for (k = 0; k < 600 && refMv !== e; k++) begin
      @(posedge ref_clk);
      g++;
      if (refMv !== p) begin
        chk(g == 8 || g > 99, 1);
        g = 0;
      end
      p = refMv;
    end
    chk(refMv, e);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ----
  // sequence
  // ----
  initial begin
    ref_clk = 0;
    forever #50 ref_clk = ~ref_clk;
  end
  initial begin
    #2_000_000;
    err_count++;
    summarize();
  end
  initial begin
    reset = 1;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 0;
    pwdata = 0;
    porReleased = 0;
    enReq = 0;
    rateSelectShutoff = 0;
    outputInWindow = 0;
    codeReq = 5'h08;
    repeat (10) @(posedge ref_clk);
    reset <= 0;
    apb(0, 8'h00, 0);
    chk(rdat, 32'h0001_0014);
    // shorter phase period keeps soft-start near 4096 clocks
    apb(1, 8'h00, 32'h0001_0002);
    porReleased <= 1;
    enReq <= 1;
    rateSelectShutoff <= 1;
    waitbit(pwmDriveEn, 1);
    n = 0;
    do begin
      apb(0, 8'h04, 0);
      n++;
    end while (rdat[1:0] !== 2'h2 && n < 3000);
    chk(n * 3 >= 4080 && n * 3 <= 4120, 1);
    chk(regulateMv, {1'b0, refMv});
    chk(rampMv, 12'h762);
    chk(rampUa, 8'h00);
    apb(0, 8'h0C, 0);
    chk(rdat[23:0], 24'h00_07FF);
    for (int i = 0; i < 5; i++) begin
      codeReq <= rowCode[i];
      slew(rowMv[i]);
      apb(0, 8'h08, 0);
      chk(rdat[10:0], rowMv[i]);
      $display("row %0d done", i);
    end
    @(posedge ch1Start);
    @(posedge ref_clk);
    codeReq <= 5'h04;
    repeat (4) @(posedge ref_clk);
    codeReq <= 5'h08;
    repeat (40) @(posedge ref_clk);
    chk(refMv, 11'h546);
    $display("glitch done");
    outputInWindow <= 1;
    waitbit(outputOkFlag, 1);
    outputInWindow <= 0;
    waitbit(outputOkFlag, 0);
    outputInWindow <= 1;
    $display("window done");
    reset <= 1;
    @(posedge ref_clk);
    chk(pwmDriveEn, 0);
    reset <= 0;
    apb(0, 8'h00, 0);
    chk(rdat, 32'h0001_0014);
    apb(1, 8'h10, 32'hFFFF_FFFF);
    chk(rerr, 1);
    apb(0, 8'h10, 0);
    chk(rerr, 1);
    chk(rdat, 32'h0000_0000);
    apb(1, 8'h08, 0);
    chk(rerr, 0);
    waitbit(pwmDriveEn, 1);
    apb(0, 8'h08, 0);
    chk({rerr, rdat[10:0]}, {1'b0, 11'h546});
    $display("reset and map done");
    for (int i = 0; i < 4; i++) begin
      case (i)
        0: porReleased <= 0;
        1: enReq <= 0;
        2: rateSelectShutoff <= 0;
        default: codeReq <= 5'h1F;
      endcase
      waitbit(pwmDriveEn, 0);
      // flag follows the state register, one cycle after drive enable
      @(posedge ref_clk);
      chk(outputOkFlag, 0);
      n = 0;
      repeat (60) @(posedge ref_clk) n += ch1Start;
      if (i == 2) chk(n, 0);
      porReleased <= 1;
      enReq <= 1;
      rateSelectShutoff <= 1;
      codeReq <= 5'h08;
      waitbit(pwmDriveEn, 1);
      apb(0, 8'h04, 0);
      chk(rdat[1:0], 2'h1);
      $display("drop %0d done", i);
    end
    summarize();
  end
endmodule

bind vss_sequencer vss_seq_chk u_chk (.ref_clk, .reset, .psel, .penable, .pready,
  .pslverr, .porReleased, .enAboveThreshold, .rateSelectShutoff, .outputInWindow,
  .voltageCode, .pwmDriveEn, .outputOkFlag, .refMv, .regulateMv, .rampUa);
